// ===== pins_pkg.sv
package pins_pkg;

	// ************************************************
	// sizes and encodings
	// ************************************************
	localparam int          NUM_XCVR        = 4;
	localparam int          LIC_W           = 8;
	localparam int          PD_BIT          = 0;
	localparam logic [1:0]  STYLE_SPLIT     = 2'h0;
	localparam logic [1:0]  STYLE_DSTROBE   = 2'h1;
	localparam logic [7:0]  LIC_RESET       = 8'h00;
	localparam logic [3:0]  SEL_RESET       = 4'h0;

	// ************************************************
	// timing
	// ************************************************
	localparam int          CLK_PERIOD_PS   = 4000;
	localparam int          CLK_LOSS_NS     = 5;
	localparam int          CLK_LOSS_UNIT   = 1000;
	localparam int          LOSS_CYC_INT    = (CLK_LOSS_NS * CLK_LOSS_UNIT * 1000 + CLK_PERIOD_PS - 1)
	                                          / CLK_PERIOD_PS;
	localparam int          CNT_W           = 11;
	localparam logic [10:0] LOSS_CYCLES     = LOSS_CYC_INT[10:0];

	// ************************************************
	// carriers
	// ************************************************
	typedef struct packed {
		logic sync_search;
		logic transmit_line_clock;
	} xcvr_in_t;

	typedef struct packed {
		logic [7:0] line_iface_ctrl_one;
		logic [3:0] monitor_select_bit;
	} cfg_t;

	typedef struct packed {
		logic tx_overflow;
		logic rx_overflow;
		logic tx_at_high_wm;
		logic rx_at_high_wm;
	} queue_in_t;

	typedef struct packed {
		logic split_strobes;
		logic data_strobe;
		logic reserved_code;
	} bus_style_t;

endpackage

// ===== reset_mode_status_pins.sv
`timescale 1ns/1ps
`default_nettype none

module reset_mode_status_pins (
	input  wire logic                                    clock_i,
	input  wire logic                                    nrst_i,
	input  wire logic                                    test_reset_pin_i,
	input  wire logic                                    tx_power_down_pin_i,
	input  wire logic [1:0]                              bus_style_strap_i,
	input  wire logic                                    cfg_wr_i,
	input  wire pins_pkg::cfg_t                          cfg_i,
	input  wire pins_pkg::xcvr_in_t [3:0]                xcvr_i,
	input  wire pins_pkg::queue_in_t                     queue_i,
	output var  pins_pkg::cfg_t                          cfg_o,
	output var  pins_pkg::bus_style_t                    bus_style_o,
	output logic [3:0]                                   tx_power_down_o,
	output logic [3:0]                                   sync_or_clock_loss_out_o,
	output logic [3:0]                                   sync_or_clock_loss_oe_o,
	output logic                                         queue_overflow_out_o,
	output logic                                         queue_overflow_oe_o,
	output logic                                         ctrl_port_oe_o,
	output logic                                         int_rst_n_o
);

	// ************************************************
	// reset synchroniser
	// ************************************************
	// chip reset is asserted at once, released two edges later
	logic rst_meta_r;
	logic rst_sync_r;
	logic int_rst;

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// nrst_i folded in so assertion is not delayed by the sync
	assign int_rst = !nrst_i || !rst_sync_r;

	always_ff @(posedge clock_i) begin
		if (!nrst_i)
			int_rst_n_o <= 1'b0;
		else
			int_rst_n_o <= rst_sync_r;
	end

	// ************************************************
	// test/reset pin
	// ************************************************
	logic tst_prev_r;
	logic tst_rise;

	always_ff @(posedge clock_i) begin
		if (int_rst)
			tst_prev_r <= 1'b0;
		else
			tst_prev_r <= test_reset_pin_i;
	end

	assign tst_rise = test_reset_pin_i && !tst_prev_r;

	// ************************************************
	// transceiver configuration registers
	// ************************************************
	logic [7:0] lic_r;
	logic [7:0] lic_nxt;
	logic [3:0] sel_r;
	logic [3:0] sel_nxt;

	// test reset wins over a write landing in the same cycle
	assign lic_nxt = tst_rise ? pins_pkg::LIC_RESET
	               : cfg_wr_i ? cfg_i.line_iface_ctrl_one : lic_r;
	assign sel_nxt = tst_rise ? pins_pkg::SEL_RESET
	               : cfg_wr_i ? cfg_i.monitor_select_bit : sel_r;

	always_ff @(posedge clock_i) begin
		if (int_rst) begin
			lic_r <= pins_pkg::LIC_RESET;
			sel_r <= pins_pkg::SEL_RESET;
		end else begin
			lic_r <= lic_nxt;
			sel_r <= sel_nxt;
		end
	end

	assign cfg_o.line_iface_ctrl_one = lic_r;
	assign cfg_o.monitor_select_bit  = sel_r;

	// ************************************************
	// output enables
	// ************************************************
	logic oe_nxt;

	assign oe_nxt = !test_reset_pin_i;

	always_ff @(posedge clock_i) begin
		if (int_rst) begin
			ctrl_port_oe_o          <= 1'b0;
			queue_overflow_oe_o     <= 1'b0;
			sync_or_clock_loss_oe_o <= 4'h0;
		end else begin
			ctrl_port_oe_o          <= oe_nxt;
			queue_overflow_oe_o     <= oe_nxt;
			sync_or_clock_loss_oe_o <= {pins_pkg::NUM_XCVR{oe_nxt}};
		end
	end

	// ************************************************
	// bus style strap
	// ************************************************
	// reserved codes are flagged, neither style selected
	function automatic pins_pkg::bus_style_t decode_style(input logic [1:0] code);
		pins_pkg::bus_style_t s;
		s.split_strobes = (code == pins_pkg::STYLE_SPLIT);
		s.data_strobe   = (code == pins_pkg::STYLE_DSTROBE);
		s.reserved_code = !s.split_strobes && !s.data_strobe;
		return s;
	endfunction

	pins_pkg::bus_style_t style_nxt;

	assign style_nxt = decode_style(bus_style_strap_i);

	always_ff @(posedge clock_i) begin
		if (int_rst)
			bus_style_o <= decode_style(pins_pkg::STYLE_SPLIT);
		else
			bus_style_o <= style_nxt;
	end

	// ************************************************
	// transmit power-down
	// ************************************************
	// either source powers the drivers down
	logic pd_nxt;

	assign pd_nxt = tx_power_down_pin_i || lic_r[pins_pkg::PD_BIT];

	always_ff @(posedge clock_i) begin
		if (int_rst)
			tx_power_down_o <= 4'h0;
		else
			tx_power_down_o <= {pins_pkg::NUM_XCVR{pd_nxt}};
	end

	// ************************************************
	// per transceiver sync / clock loss
	// ************************************************
	genvar g;
	generate
		for (g = 0; g < pins_pkg::NUM_XCVR; g++) begin : g_xcvr
			logic        clk_prev_r;
			logic [10:0] idle_cnt_r;
			logic [10:0] idle_cnt_nxt;
			logic        toggled;
			logic        clk_lost;
			logic        loss_nxt;

			assign toggled  = xcvr_i[g].transmit_line_clock != clk_prev_r;
			// counter saturates so a dead clock stays reported
			assign clk_lost = idle_cnt_r >= pins_pkg::LOSS_CYCLES;
			assign idle_cnt_nxt = toggled ? 11'h000
			                    : clk_lost ? idle_cnt_r : idle_cnt_r + 11'h001;
			assign loss_nxt = sel_r[g] ? clk_lost
			                : xcvr_i[g].sync_search;

			always_ff @(posedge clock_i) begin
				if (int_rst) begin
					clk_prev_r                  <= 1'b0;
					idle_cnt_r                  <= 11'h000;
					sync_or_clock_loss_out_o[g] <= 1'b0;
				end else begin
					clk_prev_r                  <= xcvr_i[g].transmit_line_clock;
					idle_cnt_r                  <= idle_cnt_nxt;
					sync_or_clock_loss_out_o[g] <= loss_nxt;
				end
			end
		end
	endgenerate

	// ************************************************
	// queue overflow
	// ************************************************
	// per queue flag; an overflow in the clearing cycle wins
	logic tx_ovf_r;
	logic rx_ovf_r;
	logic tx_ovf_nxt;
	logic rx_ovf_nxt;

	assign tx_ovf_nxt = queue_i.tx_overflow
	                 || (tx_ovf_r && !queue_i.tx_at_high_wm);
	assign rx_ovf_nxt = queue_i.rx_overflow
	                 || (rx_ovf_r && !queue_i.rx_at_high_wm);

	always_ff @(posedge clock_i) begin
		if (int_rst) begin
			tx_ovf_r             <= 1'b0;
			rx_ovf_r             <= 1'b0;
			queue_overflow_out_o <= 1'b0;
		end else begin
			tx_ovf_r             <= tx_ovf_nxt;
			rx_ovf_r             <= rx_ovf_nxt;
			queue_overflow_out_o <= tx_ovf_nxt || rx_ovf_nxt;
		end
	end

endmodule

`default_nettype wire

// ===== reset_mode_status_pins_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module reset_mode_status_pins_assertions (
	input wire logic                    clock_i,
	input wire logic                    nrst_i,
	input wire logic                    test_reset_pin_i,
	input wire logic                    tx_power_down_pin_i,
	input wire logic [1:0]              bus_style_strap_i,
	input wire pins_pkg::xcvr_in_t [3:0] xcvr_i,
	input wire pins_pkg::queue_in_t     queue_i,
	input wire pins_pkg::cfg_t          cfg_o,
	input wire pins_pkg::bus_style_t    bus_style_o,
	input wire logic [3:0]              tx_power_down_o,
	input wire logic [3:0]              sync_or_clock_loss_out_o,
	input wire logic [3:0]              sync_or_clock_loss_oe_o,
	input wire logic                    queue_overflow_out_o,
	input wire logic                    queue_overflow_oe_o,
	input wire logic                    ctrl_port_oe_o,
	input wire logic                    int_rst_n_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	a_test_clear: assert property ($rose(test_reset_pin_i) && int_rst_n_o |=> cfg_o == '0)
		else $error("config survived test pin rise");
	a_pins_float: assert property (test_reset_pin_i |=> !ctrl_port_oe_o && !queue_overflow_oe_o
		&& sync_or_clock_loss_oe_o == 4'h0)
		else $error("output driven while test pin high");
	a_chip_reset: assert property (disable iff (1'b0) !nrst_i |=> !int_rst_n_o && cfg_o == '0
		&& !queue_overflow_out_o)
		else $error("state kept through chip reset");
	a_reset_release: assert property ($rose(nrst_i) |-> !int_rst_n_o ##1 !int_rst_n_o ##1 !int_rst_n_o
		##1 int_rst_n_o)
		else $error("internal reset release mistimed");
	a_strap_decode: assert property (int_rst_n_o |=> bus_style_o == {$past(bus_style_strap_i) == pins_pkg::STYLE_SPLIT,
		$past(bus_style_strap_i) == pins_pkg::STYLE_DSTROBE, $past(bus_style_strap_i[1])})
		else $error("bus style decode wrong");
	a_power_down: assert property (int_rst_n_o |=> tx_power_down_o ==
		{4{$past(tx_power_down_pin_i) | $past(cfg_o.line_iface_ctrl_one[0])}})
		else $error("power-down not pin or control bit");
	a_sync_loss: assert property (int_rst_n_o && !cfg_o.monitor_select_bit[0] |=>
		sync_or_clock_loss_out_o[0] == $past(xcvr_i[0].sync_search))
		else $error("sync loss output wrong");
	a_queue_set: assert property (int_rst_n_o && (queue_i.tx_overflow || queue_i.rx_overflow)
		|=> queue_overflow_out_o)
		else $error("overflow not flagged");
endmodule
bind reset_mode_status_pins reset_mode_status_pins_assertions chk (.clock_i, .nrst_i, .test_reset_pin_i,
	.tx_power_down_pin_i, .bus_style_strap_i, .xcvr_i, .queue_i, .cfg_o, .bus_style_o, .tx_power_down_o,
	.sync_or_clock_loss_out_o, .sync_or_clock_loss_oe_o, .queue_overflow_out_o, .queue_overflow_oe_o,
	.ctrl_port_oe_o, .int_rst_n_o);
`default_nettype wire

// ===== board_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module board_ctrl (
	input  wire logic       hold_i,
	input  wire logic       style_i,
	output logic            nrst_o,
	output logic [1:0]      strap_o
);
	// held low by the bench until its clocks have run
	assign nrst_o = !hold_i;
	// reserved codes can never be formed
	assign strap_o = {1'b0, style_i};
endmodule
`default_nettype wire

// ===== reset_mode_status_pins_tb.sv
`timescale 1ns/1ps
`default_nettype none
module reset_mode_status_pins_tb;
	logic                     clock_i = 1'b0;
	logic                     hold = 1'b1;
	logic                     style = 1'b0;
	logic                     nrst_i;
	logic [1:0]               strap;
	logic                     tpin = 1'b0;
	logic                     pd = 1'b0;
	logic                     wr = 1'b0;
	pins_pkg::cfg_t           cfg = '0;
	pins_pkg::xcvr_in_t [3:0] xc = '0;
	pins_pkg::queue_in_t      q = '0;
	pins_pkg::cfg_t           cfg_o;
	pins_pkg::bus_style_t     bs;
	logic [3:0]               pdo, lo, loe;
	logic                     qo, qoe, coe, irn;
	int                       err_total = 0;
	int                       cmp_count = 0;
	int                       cyc = 0;
	always #2 clock_i = ~clock_i;
	board_ctrl BRD (.hold_i(hold), .style_i(style), .nrst_o(nrst_i), .strap_o(strap));
	reset_mode_status_pins DUT (.clock_i(clock_i), .nrst_i(nrst_i), .test_reset_pin_i(tpin),
		.tx_power_down_pin_i(pd), .bus_style_strap_i(strap), .cfg_wr_i(wr), .cfg_i(cfg), .xcvr_i(xc),
		.queue_i(q), .cfg_o(cfg_o), .bus_style_o(bs), .tx_power_down_o(pdo), .sync_or_clock_loss_out_o(lo),
		.sync_or_clock_loss_oe_o(loe), .queue_overflow_out_o(qo), .queue_overflow_oe_o(qoe),
		.ctrl_port_oe_o(coe), .int_rst_n_o(irn));
	task finish_test;
		if (err_total == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [11:0] e, input logic [11:0] s);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask
	task tick(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	task wr_cfg(input logic [11:0] v);
		wr = 1'b1;
		cfg = v;
		tick(1);
		wr = 1'b0;
	endtask
	// **********
	// scenarios
	// **********
	task t_test_pin;
		wr_cfg(12'ha5f);
		tpin = 1'b1;
		wr_cfg(12'h3c1); // lands on the rise, so it must be dropped
		chk("cfg", 12'h000, cfg_o);
		tick(3);
		chk("oe", 12'h000, {6'h0, loe, qoe, coe});
		tpin = 1'b0;
		tick(1);
		chk("oe", 12'h03f, {6'h0, loe, qoe, coe});
	endtask
	task t_strap;
		for (int i = 0; i < 2; i++) begin
			style = i[0];
			tick(2);
			chk("style", {9'h0, i == 0, i == 1, 1'b0}, {9'h0, bs});
		end
	endtask
	task t_pd;
		for (int i = 0; i < 4; i++) begin
			pd = i[0];
			wr_cfg({7'h0, i[1], 4'h0});
			tick(1);
			chk("pd", {8'h0, {4{i != 0}}}, {8'h0, pdo});
		end
	endtask
	task t_loss;
		wr_cfg(12'h000);
		for (int i = 0; i < 2; i++) begin
			for (int g = 0; g < 4; g++)
				xc[g].sync_search = i[0];
			tick(2);
			chk("sync", {8'h0, {4{i[0]}}}, {8'h0, lo});
		end
		wr_cfg(12'h00f);
		repeat (20) begin
			xc[0].transmit_line_clock = ~xc[0].transmit_line_clock;
			tick(1);
		end
		tick(1240);
		chk("loss", 12'h0, {11'h0, lo[0]});
		tick(20);
		chk("loss", 12'h00f, {8'h0, lo});
		xc[0].transmit_line_clock = ~xc[0].transmit_line_clock;
		tick(3);
		chk("loss", 12'h00e, {8'h0, lo});
	endtask
	task t_queue;
		q.tx_overflow = 1'b1;
		tick(1);
		q.tx_overflow = 1'b0;
		q.rx_at_high_wm = 1'b1; // other queue's mark must not clear it
		tick(2);
		chk("ovf", 12'h1, {11'h0, qo});
		q.tx_at_high_wm = 1'b1;
		tick(1);
		chk("ovf", 12'h0, {11'h0, qo});
		q = '0;
		q.rx_overflow = 1'b1;
		tick(1);
		q = '0;
		tick(1);
		chk("ovf", 12'h1, {11'h0, qo});
	endtask
	task t_chip_reset;
		wr_cfg(12'h5a3);
		hold = 1'b1;
		tick(1);
		chk("cfg", 12'h0, cfg_o);
		chk("ovf", 12'h0, {11'h0, qo});
		hold = 1'b0;
		tick(2);
		chk("irst", 12'h0, {11'h0, irn});
		tick(1);
		chk("irst", 12'h1, {11'h0, irn});
	endtask
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			finish_test;
		end
	end
	initial begin
		tick(4);
		hold = 1'b0;
		tick(3);
		t_test_pin;
		t_strap;
		t_pd;
		t_loss;
		t_queue;
		t_chip_reset;
		finish_test;
	end
endmodule
`default_nettype wire
